// *** logic/accsc_top.v ***
// Converter core calibration, core rotation and channel mapping control
// Contract
// - Foreground calibration forces mid-code outputs
// - Background calibration keeps converting through swaps
// - Six indexed cores, assignable or spare
// - Foreground map: 0-A, 1-B, 4-C, 5-D
// - Quad: spare 2 for 0/1, 3 for 4/5
// - Dual shares spare 2; single uses 2
// - Power-up foreground calibration; host waits
// - Trigger from pin or software bit
// - Only one core calibrated at once in background; foreground runs all six together
// - Calibrated core replaces next active, repeating
// - Calibrate linearity, gain, offset per core
// - Driven inputs tolerated during calibration
// - Trims reset factory, readable and writable
// - Trims held per core and input; the code keeps one word per core and parameter
// - Foreground once or background continuous offset
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "accsc_defs.vh"
module accsc_top (
   input wire core_clk,
   input wire srst,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire [31:0] hrdata,
   output wire hresp,
   input wire calTriggerPin,
   input wire sampleStrobe,
   input wire [71:0] coreSamples,
   output reg [11:0] outInputA_q,
   output reg [11:0] outInputB_q,
   output reg [11:0] outInputC_q,
   output reg [11:0] outInputD_q,
   output reg outValid_q,
   output wire [5:0] coreOnline,
   output wire [5:0] coreCalibrate,
   output wire [1:0] calPhase
);
   // ==========================================================
   // Helpers
   // Pick one core's 12-bit sample out of the packed bus
   function [11:0] pickCore;
      input [71:0] smp;
      input [2:0] idx;
      reg [71:0] sh;
      begin
         sh = smp >> ({3'b000, idx} * 6'd12);
         pickCore = sh[11:0];
      end
   endfunction

   // One-hot mask of a core number
   function [5:0] oneHot;
      input [2:0] idx;
      begin
         oneHot = 6'h01 << idx;
      end
   endfunction

   // ==========================================================
   // Main states
   localparam [2:0] ST_FG_START = 3'h0;
   localparam [2:0] ST_FG_RUN = 3'h1;
   localparam [2:0] ST_IDLE = 3'h2;
   localparam [2:0] ST_BG_RUN = 3'h3;
   localparam [2:0] ST_SRC_WAIT = 3'h4;
   localparam [2:0] ST_MUX_WAIT = 3'h5;

   // ==========================================================
   // Register file
   reg [6:0] ctrl_q; // Mode, trigger and offset control
   reg [7:0] srcDly_q; // Core source switch delay
   reg [7:0] muxDly_q; // Output mux switch delay
   reg [31:0] rdHold_q; // Read data for non-memory registers
   reg rdIsTrim_q; // Data phase reads trim memory
   reg wrPend_q; // Write data phase pending
   reg [9:0] wrIdx_q; // Latched write index
   wire [15:0] trimRd; // Trim memory read word
   wire [9:0] aIdx = haddr[11:2]; // Word index of address phase
   wire aValid = hsel && htrans[1] && hready; // Address phase taken
   wire [9:0] trimOffA = aIdx - `ACCSC_IDX_TRIM_BASE;
   wire [9:0] trimOffW = wrIdx_q - `ACCSC_IDX_TRIM_BASE;
   wire aTrim = (aIdx >= `ACCSC_IDX_TRIM_BASE) && (trimOffA < `ACCSC_TRIM_WORDS);
   wire wTrim = (wrIdx_q >= `ACCSC_IDX_TRIM_BASE) && (trimOffW < `ACCSC_TRIM_WORDS);

   wire bgEnable = ctrl_q[`ACCSC_CTRL_BG_EN];
   wire trigSelPin = ctrl_q[`ACCSC_CTRL_TRIG_SEL];
   wire softTrig = ctrl_q[`ACCSC_CTRL_SOFT_TRIG];
   wire fgOfsEn = ctrl_q[`ACCSC_CTRL_FG_OFS];
   wire bgOfsEn = ctrl_q[`ACCSC_CTRL_BG_OFS];
   wire [1:0] variant = ctrl_q[`ACCSC_CTRL_VAR_LO+1:`ACCSC_CTRL_VAR_LO];

   // ==========================================================
   // Rotation state
   reg [2:0] state_q; // Main state
   reg [2:0] g0s0_q, g0s1_q, g0sp_q; // Group 0 slots and spare
   reg [2:0] g1s0_q, g1s1_q, g1sp_q; // Group 1 slots and spare
   reg g0Ptr_q; // Group 0 slot to be replaced next
   reg g1Ptr_q; // Group 1 slot to be replaced next
   reg turn_q; // Group whose spare is in calibration
   reg [7:0] dlyCnt_q; // Swap delay counter
   reg trigPrev_q; // Trigger level one cycle ago
   reg fgDone_q; // Last foreground run finished
   reg [7:0] swapCnt_q; // Completed swaps
   reg calStart; // Engine start request
   reg [5:0] calMask; // Cores to calibrate
   reg calOfs; // Include offset phase
   wire calBusy;
   wire calDone;

   // Trigger source select
   wire trigLevel = trigSelPin ? calTriggerPin : softTrig;
   wire trigRise = trigLevel && !trigPrev_q;
   wire fgActive = (state_q == ST_FG_START) || (state_q == ST_FG_RUN);
   wire quad = (variant == `ACCSC_VAR_QUAD);
   wire single = (variant == `ACCSC_VAR_SINGLE);
   wire [2:0] curSpare = turn_q ? g1sp_q : g0sp_q;

   // ==========================================================
   // Core status outputs
   wire [5:0] activeSet = oneHot(g0s0_q) | (single ? 6'h00 : oneHot(g0s1_q))
                        | (quad ? (oneHot(g1s0_q) | oneHot(g1s1_q)) : 6'h00);
   wire swapping = (state_q == ST_SRC_WAIT) || (state_q == ST_MUX_WAIT);
   // Cores offline during foreground; spare joins early before the mux moves
   assign coreOnline = fgActive ? 6'h00 : (activeSet | (swapping ? oneHot(curSpare) : 6'h00));

   // ==========================================================
   // Calibration engine, shared so only one run at a time
   accsc_cal_seq u_calSeq (
      .core_clk(core_clk),
      .srst(srst),
      .calStart(calStart),
      .calMask(calMask),
      .offsetEnable(calOfs),
      .calBusy(calBusy),
      .calDone_q(calDone),
      .calPhase_q(calPhase),
      .calCores_q(coreCalibrate)
   );

   // Engine request from current state
   always @*
   begin
      calStart = 1'b0;
      calMask = 6'h00;
      calOfs = 1'b0;
      if (state_q == ST_FG_START)
      begin
         calStart = 1'b1;
         calMask = `ACCSC_ALL_CORES;
         calOfs = fgOfsEn;
      end
      else if (state_q == ST_IDLE && !trigRise && bgEnable && trigLevel)
      begin
         calStart = 1'b1;
         calMask = oneHot(curSpare);
         calOfs = bgOfsEn;
      end
   end

   // ==========================================================
   // Calibration and rotation state machine
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         state_q <= ST_FG_START;
         g0s0_q <= 3'd0;
         g0s1_q <= 3'd1;
         g0sp_q <= 3'd2;
         g1s0_q <= 3'd4;
         g1s1_q <= 3'd5;
         g1sp_q <= 3'd3;
         g0Ptr_q <= 1'b0;
         g1Ptr_q <= 1'b0;
         turn_q <= 1'b0;
         dlyCnt_q <= 8'h00;
         trigPrev_q <= 1'b0;
         fgDone_q <= 1'b0;
         swapCnt_q <= 8'h00;
      end
      else
      begin
         trigPrev_q <= trigLevel;
         case (state_q)
            ST_FG_START:
            begin
               // Engine takes the request this cycle
               fgDone_q <= 1'b0;
               state_q <= ST_FG_RUN;
            end
            ST_FG_RUN:
            begin
               if (calDone)
               begin
                  // Restore the fixed foreground map
                  g0s0_q <= 3'd0;
                  g0s1_q <= 3'd1;
                  g1s0_q <= 3'd4;
                  g1s1_q <= 3'd5;
                  g0sp_q <= 3'd2;
                  g1sp_q <= 3'd3;
                  g0Ptr_q <= 1'b0;
                  g1Ptr_q <= 1'b0;
                  turn_q <= 1'b0;
                  fgDone_q <= 1'b1;
                  state_q <= ST_IDLE;
               end
            end
            ST_IDLE:
            begin
               // New trigger edge restarts foreground; else rotate spares
               if (trigRise)
                  state_q <= ST_FG_START;
               else if (calStart)
                  state_q <= ST_BG_RUN;
            end
            ST_BG_RUN:
            begin
               if (calDone)
               begin
                  dlyCnt_q <= 8'h00;
                  state_q <= ST_SRC_WAIT;
               end
            end
            ST_SRC_WAIT:
            begin
               // Fresh core runs ahead of the switch for the source delay
               if (dlyCnt_q >= srcDly_q)
               begin
                  dlyCnt_q <= 8'h00;
                  state_q <= ST_MUX_WAIT;
               end
               else
                  dlyCnt_q <= dlyCnt_q + 8'h01;
            end
            ST_MUX_WAIT:
            begin
               if (dlyCnt_q < muxDly_q)
                  dlyCnt_q <= dlyCnt_q + 8'h01;
               else if (sampleStrobe)
               begin
                  // Swap only between samples
                  swapCnt_q <= swapCnt_q + 8'h01;
                  state_q <= ST_IDLE;
                  if (!turn_q)
                  begin
                     // Group 0: spare replaces next active core
                     if (g0Ptr_q && !single)
                     begin
                        g0s1_q <= g0sp_q;
                        g0sp_q <= g0s1_q;
                     end
                     else
                     begin
                        g0s0_q <= g0sp_q;
                        g0sp_q <= g0s0_q;
                     end
                     g0Ptr_q <= single ? 1'b0 : !g0Ptr_q;
                  end
                  else
                  begin
                     // Group 1 exists in the quad variant only
                     if (g1Ptr_q)
                     begin
                        g1s1_q <= g1sp_q;
                        g1sp_q <= g1s1_q;
                     end
                     else
                     begin
                        g1s0_q <= g1sp_q;
                        g1sp_q <= g1s0_q;
                     end
                     g1Ptr_q <= !g1Ptr_q;
                  end
                  turn_q <= quad ? !turn_q : 1'b0;
               end
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Output sample path, inputs stay live during background calibration
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         outInputA_q <= `ACCSC_MID_CODE;
         outInputB_q <= `ACCSC_MID_CODE;
         outInputC_q <= `ACCSC_MID_CODE;
         outInputD_q <= `ACCSC_MID_CODE;
         outValid_q <= 1'b0;
      end
      else
      begin
         outValid_q <= sampleStrobe;
         if (sampleStrobe)
         begin
            if (fgActive)
            begin
               // Cores offline, outputs parked at mid-code
               outInputA_q <= `ACCSC_MID_CODE;
               outInputB_q <= `ACCSC_MID_CODE;
               outInputC_q <= `ACCSC_MID_CODE;
               outInputD_q <= `ACCSC_MID_CODE;
            end
            else
            begin
               // Current map; swap takes effect from the next sample
               outInputA_q <= pickCore(coreSamples, g0s0_q);
               outInputB_q <= single ? `ACCSC_MID_CODE : pickCore(coreSamples, g0s1_q);
               outInputC_q <= quad ? pickCore(coreSamples, g1s0_q) : `ACCSC_MID_CODE;
               outInputD_q <= quad ? pickCore(coreSamples, g1s1_q) : `ACCSC_MID_CODE;
            end
         end
      end
   end

   // ==========================================================
   // AHB-Lite slave, zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdIsTrim_q ? {16'h0000, trimRd} : rdHold_q;

   // Address phase capture and register writes
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         ctrl_q <= `ACCSC_CTRL_RESET;
         srcDly_q <= `ACCSC_DLY_RESET;
         muxDly_q <= `ACCSC_DLY_RESET;
         rdHold_q <= 32'h00000000;
         rdIsTrim_q <= 1'b0;
         wrPend_q <= 1'b0;
         wrIdx_q <= 10'h000;
      end
      else
      begin
         wrPend_q <= aValid && hwrite;
         wrIdx_q <= aIdx;
         rdIsTrim_q <= aValid && !hwrite && aTrim;
         // Data phase write of control and delay registers
         if (wrPend_q)
         begin
            case (wrIdx_q)
               `ACCSC_IDX_CTRL: ctrl_q <= hwdata[6:0];
               `ACCSC_IDX_SRC_DLY: srcDly_q <= hwdata[7:0];
               `ACCSC_IDX_MUX_DLY: muxDly_q <= hwdata[7:0];
               default: ctrl_q <= ctrl_q;
            endcase
         end
         // Read value prepared at the address phase
         if (aValid && !hwrite)
         begin
            case (aIdx)
               `ACCSC_IDX_CTRL: rdHold_q <= {25'h0000000, ctrl_q};
               `ACCSC_IDX_SRC_DLY: rdHold_q <= {24'h000000, srcDly_q};
               `ACCSC_IDX_MUX_DLY: rdHold_q <= {24'h000000, muxDly_q};
               `ACCSC_IDX_STATUS: rdHold_q <= {15'h0000, fgDone_q, swapCnt_q, g1sp_q, g0sp_q,
                                                calBusy, fgActive};
               default: rdHold_q <= 32'h00000000;
            endcase
         end
      end
   end

   // Trim words, one per core and parameter
   accsc_trim_mem u_trimMem (
      .core_clk(core_clk),
      .srst(srst),
      .wrEn(wrPend_q && wTrim),
      .wrAddr(trimOffW[4:0]),
      .wrData(hwdata[15:0]),
      .rdAddr(trimOffA[4:0]),
      .rdData_q(trimRd)
   );
endmodule

// *** logic/accsc_defs.vh ***
// Constants of the converter core calibration and swap controller
`ifndef ACCSC_DEFS_VH
`define ACCSC_DEFS_VH
// ==========================================================
// Register indices (byte address is four times the index)
`define ACCSC_IDX_SRC_DLY 10'h09A
`define ACCSC_IDX_MUX_DLY 10'h09B
`define ACCSC_IDX_CTRL 10'h080
`define ACCSC_IDX_STATUS 10'h081
`define ACCSC_IDX_TRIM_BASE 10'h0A0
`define ACCSC_TRIM_WORDS 18
// ==========================================================
// Control register fields
`define ACCSC_CTRL_BG_EN 0
`define ACCSC_CTRL_TRIG_SEL 1
`define ACCSC_CTRL_SOFT_TRIG 2
`define ACCSC_CTRL_FG_OFS 3
`define ACCSC_CTRL_BG_OFS 4
`define ACCSC_CTRL_VAR_LO 5
`define ACCSC_CTRL_RESET 7'h00
`define ACCSC_DLY_RESET 8'h00
// ==========================================================
// Variant codes
`define ACCSC_VAR_QUAD 2'h0
`define ACCSC_VAR_DUAL 2'h1
`define ACCSC_VAR_SINGLE 2'h2
// ==========================================================
// Core numbering and sample format
`define ACCSC_CORES 6
`define ACCSC_MID_CODE 12'h000
`define ACCSC_ALL_CORES 6'h3F
// ==========================================================
// Calibration phase timing
`define ACCSC_CAL_PHASE_NS 1000
`define ACCSC_CLK_MHZ 125
`define ACCSC_CAL_PHASE_CYC ((`ACCSC_CAL_PHASE_NS * `ACCSC_CLK_MHZ + 999) / 1000)
// Arbitrary neutral factory trim seed
`define ACCSC_TRIM_FACTORY 16'h0080
`endif

// *** logic/accsc_trim_mem.v ***
// Trim word memory with factory reset values and registered read
`timescale 1ns/1ps
`include "accsc_defs.vh"
module accsc_trim_mem (
   input wire core_clk,
   input wire srst,
   input wire wrEn,
   input wire [4:0] wrAddr,
   input wire [15:0] wrData,
   input wire [4:0] rdAddr,
   output reg [15:0] rdData_q
);
   // ==========================================================
   // Storage
   reg [15:0] trimMem [0:`ACCSC_TRIM_WORDS-1]; // One word per core and parameter
   integer i;

   // Reset loads factory words, else write; read is registered with bypass
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         for (i = 0; i < `ACCSC_TRIM_WORDS; i = i + 1)
            trimMem[i] <= `ACCSC_TRIM_FACTORY + i[15:0];
         rdData_q <= 16'h0000;
      end
      else
      begin
         if (wrEn)
            trimMem[wrAddr] <= wrData;
         // Fresh write data wins over stale array contents
         if (wrEn && (wrAddr == rdAddr))
            rdData_q <= wrData;
         else
            rdData_q <= trimMem[rdAddr];
      end
   end
endmodule

// *** logic/accsc_cal_seq.v ***
// Calibration sequencer stepping linearity, gain and offset phases
`timescale 1ns/1ps
`include "accsc_defs.vh"
module accsc_cal_seq (
   input wire core_clk,
   input wire srst,
   input wire calStart,
   input wire [5:0] calMask,
   input wire offsetEnable,
   output wire calBusy,
   output reg calDone_q,
   output reg [1:0] calPhase_q,
   output reg [5:0] calCores_q
);
   // ==========================================================
   // Phase codes
   localparam [1:0] PH_IDLE = 2'h0;
   localparam [1:0] PH_LIN = 2'h1;
   localparam [1:0] PH_GAIN = 2'h2;
   localparam [1:0] PH_OFS = 2'h3;
   localparam integer PHASE_CYC = `ACCSC_CAL_PHASE_CYC;
   localparam [7:0] PHASE_LAST = PHASE_CYC[7:0] - 8'h01;

   reg [7:0] phaseCnt_q; // Cycles spent in current phase
   reg withOfs_q; // Offset phase requested for this run

   assign calBusy = (calPhase_q != PH_IDLE);

   // ==========================================================
   // Phase sequencer
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         calPhase_q <= PH_IDLE;
         phaseCnt_q <= 8'h00;
         withOfs_q <= 1'b0;
         calCores_q <= 6'h00;
         calDone_q <= 1'b0;
      end
      else
      begin
         calDone_q <= 1'b0;
         case (calPhase_q)
            PH_IDLE:
            begin
               // Start a run on the selected cores
               if (calStart)
               begin
                  calPhase_q <= PH_LIN;
                  calCores_q <= calMask;
                  withOfs_q <= offsetEnable;
                  phaseCnt_q <= 8'h00;
               end
            end
            default:
            begin
               if (phaseCnt_q == PHASE_LAST)
               begin
                  phaseCnt_q <= 8'h00;
                  // Linearity, then gain, then optional offset
                  if (calPhase_q == PH_LIN)
                     calPhase_q <= PH_GAIN;
                  else if (calPhase_q == PH_GAIN && withOfs_q)
                     calPhase_q <= PH_OFS;
                  else
                  begin
                     calPhase_q <= PH_IDLE;
                     calCores_q <= 6'h00;
                     calDone_q <= 1'b1;
                  end
               end
               else
                  phaseCnt_q <= phaseCnt_q + 8'h01;
            end
         endcase
      end
   end
endmodule

// *** verif/accsc_host_model.sv ***
// Host side model: trigger pin driver and sample boundary strobe
`timescale 1ns/1ps
module accsc_host_model (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic pinReq,
   output logic calTriggerPin,
   output logic sampleStrobe
);
   // ==========================================================
   // Strobe divider
   logic [1:0] div_q; // Sample boundary every fourth cycle

   // Pin follows the bench request, strobe runs free
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         div_q <= 2'h0;
         calTriggerPin <= 1'b0;
         sampleStrobe <= 1'b0;
      end
      else
      begin
         div_q <= div_q + 2'h1;
         calTriggerPin <= pinReq;
         sampleStrobe <= (div_q == 2'h3);
      end
   end
endmodule

// *** verif/accsc_chk.sv ***
// Port checker of the calibration and core swap controller
`timescale 1ns/1ps
module accsc_chk (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic sampleStrobe,
   input wire logic [11:0] outInputA_q,
   input wire logic [11:0] outInputB_q,
   input wire logic [11:0] outInputC_q,
   input wire logic [11:0] outInputD_q,
   input wire logic outValid_q,
   input wire logic [5:0] coreOnline,
   input wire logic [5:0] coreCalibrate,
   input wire logic [1:0] calPhase
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   // ==========================================================
   // Phase length counter
   logic [7:0] phCnt_q; // Cycles the phase has stood
   logic [1:0] lastPh_q; // Phase seen one cycle earlier

   // Restart the count whenever the phase moves
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         phCnt_q <= 8'h00;
         lastPh_q <= 2'h0;
      end
      else
      begin
         phCnt_q <= (calPhase != lastPh_q) ? 8'h00 : phCnt_q + 8'h01;
         lastPh_q <= calPhase;
      end
   end
   // ==========================================================
   // Properties
   property p_midcode;
      outValid_q && $past(coreCalibrate) == 6'h3F && coreCalibrate == 6'h3F |->
         {outInputA_q, outInputB_q, outInputC_q, outInputD_q} == 48'h000000000000;
   endproperty
   a_midcode: assert property (p_midcode)
      else $error("channel output not mid-code during foreground run");
   property p_fgOffline;
      coreCalibrate == 6'h3F |-> coreOnline == 6'h00;
   endproperty
   a_fgOffline: assert property (p_fgOffline)
      else $error("core online during foreground run");
   property p_valid;
      sampleStrobe |=> outValid_q;
   endproperty
   a_valid: assert property (p_valid)
      else $error("sample dropped");
   property p_noValid;
      !sampleStrobe |=> !outValid_q;
   endproperty
   a_noValid: assert property (p_noValid)
      else $error("sample emitted without boundary");
   property p_oneCore;
      coreCalibrate != 6'h3F |-> $onehot0(coreCalibrate);
   endproperty
   a_oneCore: assert property (p_oneCore)
      else $error("more than one core in background calibration");
   property p_phaseLink;
      (calPhase != 2'h0) == (coreCalibrate != 6'h00);
   endproperty
   a_phaseLink: assert property (p_phaseLink)
      else $error("phase and calibrated cores disagree");
   property p_phaseLen;
      calPhase != lastPh_q && lastPh_q != 2'h0 && calPhase != 2'h0 |-> phCnt_q >= 8'd123 && phCnt_q <= 8'd125;
   endproperty
   a_phaseLen: assert property (p_phaseLen)
      else $error("calibration phase of wrong length");
   property p_powerUp;
      $fell(srst) |-> ##[0:3] coreCalibrate == 6'h3F;
   endproperty
   a_powerUp: assert property (p_powerUp)
      else $error("no foreground run after reset");
endmodule

bind accsc_top accsc_chk u_accsc_chk (
   .core_clk(core_clk),
   .srst(srst),
   .sampleStrobe(sampleStrobe),
   .outInputA_q(outInputA_q),
   .outInputB_q(outInputB_q),
   .outInputC_q(outInputC_q),
   .outInputD_q(outInputD_q),
   .outValid_q(outValid_q),
   .coreOnline(coreOnline),
   .coreCalibrate(coreCalibrate),
   .calPhase(calPhase)
);

// *** verif/tb_adc_core_calibration_swap_control.sv ***
// Self-checking bench of the calibration and core swap controller
`timescale 1ns/1ps
`include "accsc_defs.vh"
module tb_adc_core_calibration_swap_control;
   // ==========================================================
   // Signals
   logic core_clk, srst, hsel, hwrite, pinReq, hreadyout, hresp, calTriggerPin, sampleStrobe, outValid_q;
   logic [31:0] haddr, hwdata, hrdata, rd, r0, w, seed;
   logic [1:0] htrans, calPhase;
   logic [2:0] hsize;
   logic [71:0] coreSamples, smpQ; // Samples and copy taken at the strobe
   logic [11:0] outInputA_q, outInputB_q, outInputC_q, outInputD_q;
   logic [5:0] coreOnline, coreCalibrate;
   int n_errors, n_tests, cycles, mode, vrnt, i, k;

   accsc_top u_accsc_top (.core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .calTriggerPin(calTriggerPin), .sampleStrobe(sampleStrobe),
      .coreSamples(coreSamples), .outInputA_q(outInputA_q), .outInputB_q(outInputB_q),
      .outInputC_q(outInputC_q), .outInputD_q(outInputD_q), .outValid_q(outValid_q),
      .coreOnline(coreOnline), .coreCalibrate(coreCalibrate), .calPhase(calPhase));
   accsc_host_model u_accsc_host_model (.core_clk(core_clk), .srst(srst), .pinReq(pinReq),
      .calTriggerPin(calTriggerPin), .sampleStrobe(sampleStrobe));
   // ==========================================================
   // Helpers
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // True when x is the sample of one of three cores from base b
   function automatic bit in3(logic [11:0] x, int b);
      return x === smpQ[b*12+:12] || x === smpQ[b*12+12+:12] || x === smpQ[b*12+24+:12];
   endfunction
   // Expected channel mapping for the current mode and variant
   function automatic bit mapOk();
      if (mode == 1)
         return outInputA_q === smpQ[11:0] && outInputB_q === smpQ[23:12] &&
            outInputC_q === smpQ[59:48] && outInputD_q === smpQ[71:60];
      return in3(outInputA_q, 0) && (vrnt == 2 ? outInputB_q === 12'h000 : in3(outInputB_q, 0)) &&
         (vrnt == 0 ? in3(outInputC_q, 3) && in3(outInputD_q, 3) : {outInputC_q, outInputD_q} === 24'h000000);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One AHB single transfer, entered just after a rising edge
   task ahb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h00000, idx, 2'h0};
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      check(hresp, 1'b0);
   endtask
   task wr(input logic [9:0] idx, input logic [31:0] d);
      ahb(1'b1, idx, d);
   endtask
   task rg(input logic [9:0] idx);
      ahb(1'b0, idx, 32'h0);
   endtask
   // Poll status until no foreground run is active
   task waitIdle();
      rd = 32'h1;
      repeat (2) @(posedge core_clk);
      for (k = 0; k < 400 && rd[0] !== 1'b0; k++)
         rg(`ACCSC_IDX_STATUS);
      check(rd[0], 1'b0);
   endtask
   task stop_test();
      if (n_errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ==========================================================
   // Clock
   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // Random samples (no DC content), map monitor and hang limit
   always @(posedge core_clk)
   begin
      coreSamples <= 72'({xs(), xs(), xs()});
      if (sampleStrobe === 1'b1)
         smpQ <= coreSamples;
      if (outValid_q === 1'b1 && mode == 1)
         check(mapOk(), 1'b1);
      if (outValid_q === 1'b1 && mode == 2)
         check(mapOk(), 1'b1);
      cycles++;
      if (cycles == 30000)
      begin
         n_errors++;
         stop_test();
      end
   end
   // ==========================================================
   // Main sequence
   initial
   begin
      seed = 32'h1C121540;
      srst = 1'b1;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      pinReq = 1'b0;
      mode = 0;
      vrnt = 0;
      repeat (8) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      rg(`ACCSC_IDX_STATUS);
      check(rd[0], 1'b1);
      waitIdle();
      check(rd[16], 1'b1);
      for (i = 0; i < `ACCSC_TRIM_WORDS; i++)
      begin
         rg(10'(`ACCSC_IDX_TRIM_BASE + i));
         check(rd, `ACCSC_TRIM_FACTORY + i);
         w = xs() & 32'h0000FFFF;
         wr(10'(`ACCSC_IDX_TRIM_BASE + i), w);
         rg(10'(`ACCSC_IDX_TRIM_BASE + i));
         check(rd, w);
      end
      rg(`ACCSC_IDX_SRC_DLY);
      check(rd, 32'h0);
      wr(`ACCSC_IDX_SRC_DLY, 32'h1F);
      wr(`ACCSC_IDX_MUX_DLY, 32'h1E);
      rg(`ACCSC_IDX_SRC_DLY);
      check(rd, 32'h1F);
      rg(`ACCSC_IDX_MUX_DLY);
      check(rd, 32'h1E);
      rg(10'h3FF);
      check(rd, 32'h0);
      mode <= 1;
      repeat (40) @(posedge core_clk);
      mode <= 0;
      wr(`ACCSC_IDX_CTRL, 32'h8);
      wr(`ACCSC_IDX_CTRL, 32'hC);
      for (k = 0; k < 600 && calPhase !== 2'h3; k++)
         @(posedge core_clk);
      check(calPhase, 2'h3);
      waitIdle();
      wr(`ACCSC_IDX_CTRL, 32'h2);
      wr(`ACCSC_IDX_CTRL, 32'h6);
      rg(`ACCSC_IDX_STATUS);
      check(rd[0], 1'b0);
      pinReq <= 1'b1;
      repeat (4) @(posedge core_clk);
      rg(`ACCSC_IDX_STATUS);
      check(rd[0], 1'b1);
      pinReq <= 1'b0;
      waitIdle();
      // Background rotation in each variant
      for (vrnt = 0; vrnt < 3; vrnt++)
      begin
         wr(`ACCSC_IDX_CTRL, (vrnt << 5) | 32'h11);
         wr(`ACCSC_IDX_CTRL, (vrnt << 5) | 32'h15);
         waitIdle();
         r0 = rd;
         mode <= 2;
         repeat (2000) @(posedge core_clk);
         mode <= 0;
         rg(`ACCSC_IDX_STATUS);
         check(8'(rd[15:8] - r0[15:8]) >= 8'd3, 1'b1);
         wr(`ACCSC_IDX_CTRL, 32'h0);
      end
      stop_test();
   end
endmodule
